// ---- hdl/pbs_pkg.sv ----
// shared constants, types and state names for the basic status management block
package pbs_pkg;

    // ****************************************************************
    // management register addresses
    // ****************************************************************
    localparam logic [4:0]  PBS_REG_BASIC_STATUS = 5'h01;
    localparam logic [4:0]  PBS_REG_ID_HIGH      = 5'h02;
    localparam logic [4:0]  PBS_REG_ID_LOW       = 5'h03;

    // ****************************************************************
    // basic_status bit positions
    // ****************************************************************
    localparam int          PBS_BIT_T4           = 15;
    localparam int          PBS_BIT_TX_FD        = 14;
    localparam int          PBS_BIT_TX_HD        = 13;
    localparam int          PBS_BIT_TE_FD        = 12;
    localparam int          PBS_BIT_TE_HD        = 11;
    localparam int          PBS_BIT_T2_FD        = 10;
    localparam int          PBS_BIT_T2_HD        = 9;
    localparam int          PBS_BIT_EXT_STATUS   = 8;
    localparam int          PBS_BIT_RESERVED     = 7;
    localparam int          PBS_BIT_PRE_SUPPRESS = 6;
    localparam int          PBS_BIT_AN_DONE      = 5;
    localparam int          PBS_BIT_REMOTE_FAULT = 4;
    localparam int          PBS_BIT_AN_ABILITY   = 3;
    localparam int          PBS_BIT_LINK_UP      = 2;
    localparam int          PBS_BIT_JABBER       = 1;
    localparam int          PBS_BIT_EXT_CAP      = 0;

    // ****************************************************************
    // management frame fields
    // ****************************************************************
    localparam logic [5:0]  PBS_PREAMBLE_LEN     = 6'd32;
    localparam logic        PBS_ST_FIRST         = 1'b0;
    localparam logic        PBS_ST_SECOND        = 1'b1;
    localparam logic [1:0]  PBS_OP_READ          = 2'b10;
    localparam logic [1:0]  PBS_OP_WRITE         = 2'b01;
    localparam logic [1:0]  PBS_TA_WRITE         = 2'b10;
    localparam logic        PBS_TA_DRIVE         = 1'b0;
    localparam logic [4:0]  PBS_OP_BITS          = 5'd2;
    localparam logic [4:0]  PBS_ADDR_BITS        = 5'd10;
    localparam logic [4:0]  PBS_TA_BITS          = 5'd2;
    localparam logic [4:0]  PBS_DATA_BITS        = 5'd16;
    localparam logic        PBS_IDLE_LEVEL       = 1'b1;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic an_complete;
        logic remote_fault;
        logic link_ok;
        logic jabber;
        logic speed_10;
    } pbs_status_in_s;

    typedef struct packed {
        logic an_done;
        logic remote_fault;
        logic link_up;
        logic jabber;
    } pbs_latch_s;

    typedef enum logic [2:0] {
        PBS_ST_PRE,
        PBS_ST_IDLE,
        PBS_ST_START,
        PBS_ST_OP,
        PBS_ST_ADDR,
        PBS_ST_TA,
        PBS_ST_RDATA,
        PBS_ST_WDATA
    } pbs_state_e;

endpackage : pbs_pkg

// ---- hdl/pbs_sync2.sv ----
// two-flop synchroniser for the management pins
module pbs_sync2
    import pbs_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage; idle level is high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pbs_sync2

// ---- hdl/pbs_status_latch.sv ----
// latched status bits of the basic status register
module pbs_status_latch
    import pbs_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  pbs_status_in_s      status_in,
    input  wire logic           rearm,
    input  pbs_latch_s          reported,
    output pbs_latch_s          latched
);

    logic jabber_event;

    // jabber only counts while running at 10 Mbit/s
    assign jabber_event = status_in.jabber & status_in.speed_10;

    // ****************************************************************
    // latch update; a new event wins over the clear of a read
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latched <= '0;
        end else begin
            latched.an_done      <= status_in.an_complete;
            // only the value that was shifted out is cleared
            latched.remote_fault <= status_in.remote_fault
                                  | (latched.remote_fault
                                     & ~(rearm & reported.remote_fault));
            latched.jabber       <= jabber_event
                                  | (latched.jabber & ~(rearm & reported.jabber));
            // low latch: a failure drops it, a read with good link lifts it
            latched.link_up      <= status_in.link_ok
                                  & (latched.link_up | rearm);
        end
    end

endmodule : pbs_status_latch

// ---- hdl/pbs_basic_status.sv ----
// serial management slave holding the basic status and identifier registers
//
// Behaviour
// - bits 14 to 11 always read one: TX and Te duplex capabilities.
// - bits 15, 10 and 9 always read zero: no T4, no T2.
// - bit 8 always one: extended gigabit status register exists.
// - bit 7 reserved, reads zero; controller writes zero.
// - bit 6 one; frames accepted without preamble after first 32 ones.
// - bit 5 shows auto-negotiation done; zero after reset.
// - bit 4 latches remote fault, cleared only by read or reset.
// - bit 3 always one: auto-negotiation ability.
// - bit 2 drops on link failure, rises only on good link and read.
// - bit 1 latches jabber at 10 Mbit/s until read or reset.
// - bit 0 always one: extended register set present.
// - identifier registers present one 32-bit identifier code.
// - basic status answers at register address one over management.
// - latched-high bits hold one, latched-low bits hold zero until read.
module pbs_basic_status
    import pbs_pkg::*;
#(
    parameter logic [4:0]  PHY_ADDR = 5'h00,
    parameter logic [31:0] ID_CODE  = 32'h0012_3450 // arbitrary identifier value
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe_n,
    input  pbs_status_in_s  status_in
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [1:0]  pins_sync;
    logic        mdc_s;
    logic        mdio_s;
    logic        mdc_d_reg;
    logic        mdc_rise;

    pbs_state_e  state_reg;
    logic [4:0]  bit_cnt_reg;
    logic [5:0]  pre_cnt_reg;
    logic [1:0]  op_reg;
    logic [9:0]  addr_reg;
    logic        ta_first_reg;

    logic [15:0] tx_shift_reg;
    pbs_latch_s  snap_reg;
    logic        rearm_reg;
    pbs_latch_s  latched;

    logic        is_read;
    logic        addr_hit;
    logic        drive_start;
    logic        drive_ta_end;
    logic        drive_last;

    // ****************************************************************
    // helpers
    // ****************************************************************

    // true on the sample that completes a field of n bits
    function automatic logic field_done(input logic [4:0] cnt, input logic [4:0] n);
        field_done = (cnt == (n - 5'd1));
    endfunction : field_done

    // content of one management register
    function automatic logic [15:0] reg_value(input logic [4:0] regad,
                                              input pbs_latch_s lat);
        logic [15:0] v;
        v = '0;
        case (regad)
            PBS_REG_BASIC_STATUS: begin
                v[PBS_BIT_TX_FD]        = 1'b1;
                v[PBS_BIT_TX_HD]        = 1'b1;
                v[PBS_BIT_TE_FD]        = 1'b1;
                v[PBS_BIT_TE_HD]        = 1'b1;
                v[PBS_BIT_T4]           = 1'b0;
                v[PBS_BIT_T2_FD]        = 1'b0;
                v[PBS_BIT_T2_HD]        = 1'b0;
                v[PBS_BIT_EXT_STATUS]   = 1'b1;
                v[PBS_BIT_RESERVED]     = 1'b0;
                v[PBS_BIT_PRE_SUPPRESS] = 1'b1;
                v[PBS_BIT_AN_DONE]      = lat.an_done;
                v[PBS_BIT_REMOTE_FAULT] = lat.remote_fault;
                v[PBS_BIT_AN_ABILITY]   = 1'b1;
                v[PBS_BIT_LINK_UP]      = lat.link_up;
                v[PBS_BIT_JABBER]       = lat.jabber;
                v[PBS_BIT_EXT_CAP]      = 1'b1;
            end
            PBS_REG_ID_HIGH: begin
                v = ID_CODE[31:16];
            end
            PBS_REG_ID_LOW: begin
                v = ID_CODE[15:0];
            end
            default: begin
                v = '0; // unmapped registers read zero
            end
        endcase
        reg_value = v;
    endfunction : reg_value

    // ****************************************************************
    // pin synchronisation and clock edge detection
    // ****************************************************************
    pbs_sync2 #(
        .WIDTH    (2)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({mdc, mdio_in}),
        .sync_out (pins_sync)
    );

    assign mdc_s  = pins_sync[1];
    assign mdio_s = pins_sync[0];

    // delayed management clock for rising edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mdc_d_reg <= 1'b1;
        end else begin
            mdc_d_reg <= mdc_s;
        end
    end

    assign mdc_rise = mdc_s & ~mdc_d_reg;

    // ****************************************************************
    // frame decode
    // ****************************************************************
    assign is_read      = (op_reg == PBS_OP_READ);
    assign addr_hit     = (addr_reg[9:5] == PHY_ADDR);
    // end of first turnaround bit of a read addressed to us
    assign drive_start  = mdc_rise && (state_reg == PBS_ST_TA) && (bit_cnt_reg == 5'd0)
                        && is_read && addr_hit;
    assign drive_ta_end = mdc_rise && (state_reg == PBS_ST_TA) && (bit_cnt_reg != 5'd0)
                        && is_read && addr_hit;
    assign drive_last   = mdc_rise && (state_reg == PBS_ST_RDATA) && addr_hit
                        && field_done(bit_cnt_reg, PBS_DATA_BITS);

    // frame sequencer, one step per management clock rising edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg    <= PBS_ST_PRE;
            bit_cnt_reg  <= '0;
            pre_cnt_reg  <= '0;
            op_reg       <= '0;
            addr_reg     <= '0;
            ta_first_reg <= 1'b0;
        end else if (mdc_rise) begin
            case (state_reg)
                PBS_ST_PRE: begin
                    // full preamble needed only after reset or a bad frame
                    if (mdio_s == PBS_IDLE_LEVEL) begin
                        if (pre_cnt_reg == (PBS_PREAMBLE_LEN - 6'd1)) begin
                            state_reg   <= PBS_ST_IDLE;
                            pre_cnt_reg <= '0;
                        end else begin
                            pre_cnt_reg <= pre_cnt_reg + 6'd1;
                        end
                    end else begin
                        pre_cnt_reg <= '0;
                    end
                end
                PBS_ST_IDLE: begin
                    // preamble may be suppressed: wait straight for start
                    if (mdio_s == PBS_ST_FIRST) begin
                        state_reg <= PBS_ST_START;
                    end
                end
                PBS_ST_START: begin
                    bit_cnt_reg <= '0;
                    if (mdio_s == PBS_ST_SECOND) begin
                        state_reg <= PBS_ST_OP;
                    end else begin
                        state_reg <= PBS_ST_IDLE;
                    end
                end
                PBS_ST_OP: begin
                    op_reg <= {op_reg[0], mdio_s};
                    if (field_done(bit_cnt_reg, PBS_OP_BITS)) begin
                        bit_cnt_reg <= '0;
                        if (({op_reg[0], mdio_s} == PBS_OP_READ)
                            || ({op_reg[0], mdio_s} == PBS_OP_WRITE)) begin
                            state_reg <= PBS_ST_ADDR;
                        end else begin
                            state_reg   <= PBS_ST_PRE;
                            pre_cnt_reg <= '0;
                        end
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                end
                PBS_ST_ADDR: begin
                    addr_reg <= {addr_reg[8:0], mdio_s};
                    if (field_done(bit_cnt_reg, PBS_ADDR_BITS)) begin
                        bit_cnt_reg <= '0;
                        state_reg   <= PBS_ST_TA;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                end
                PBS_ST_TA: begin
                    ta_first_reg <= mdio_s;
                    if (field_done(bit_cnt_reg, PBS_TA_BITS)) begin
                        bit_cnt_reg <= '0;
                        if (is_read) begin
                            state_reg <= PBS_ST_RDATA;
                        end else if ({ta_first_reg, mdio_s} == PBS_TA_WRITE) begin
                            state_reg <= PBS_ST_WDATA;
                        end else begin
                            state_reg   <= PBS_ST_PRE;
                            pre_cnt_reg <= '0;
                        end
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                end
                PBS_ST_RDATA, PBS_ST_WDATA: begin
                    // written data is discarded: every bit here is read-only
                    if (field_done(bit_cnt_reg, PBS_DATA_BITS)) begin
                        bit_cnt_reg <= '0;
                        state_reg   <= PBS_ST_IDLE;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                end
                default: begin
                    state_reg <= PBS_ST_PRE;
                end
            endcase
        end
    end

    // ****************************************************************
    // read data driver
    // ****************************************************************

    // drive zero in second turnaround bit, then sixteen data bits msb first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mdio_out     <= PBS_IDLE_LEVEL;
            mdio_oe_n    <= 1'b1;
            tx_shift_reg <= '0;
        end else if (drive_start) begin
            mdio_out     <= PBS_TA_DRIVE;
            mdio_oe_n    <= 1'b0;
            tx_shift_reg <= reg_value(addr_reg[4:0], latched);
        end else if (drive_ta_end) begin
            mdio_out     <= tx_shift_reg[15];
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
        end else if (drive_last) begin
            mdio_out     <= PBS_IDLE_LEVEL; // release after the last data bit
            mdio_oe_n    <= 1'b1;
        end else if (mdc_rise && (state_reg == PBS_ST_RDATA) && addr_hit) begin
            mdio_out     <= tx_shift_reg[15];
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
        end
    end

    // ****************************************************************
    // clear on read
    // ****************************************************************

    // snapshot what is shifted out; re-arm once a read of the basic status register ends
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            snap_reg  <= '0;
            rearm_reg <= 1'b0;
        end else begin
            if (drive_start) begin
                snap_reg <= latched;
            end
            rearm_reg <= drive_last && (addr_reg[4:0] == PBS_REG_BASIC_STATUS);
        end
    end

    pbs_status_latch u_latch (
        .clk       (clk),
        .rst_n     (rst_n),
        .status_in (status_in),
        .rearm     (rearm_reg),
        .reported  (snap_reg),
        .latched   (latched)
    );

endmodule : pbs_basic_status

// ---- testbench/pbs_basic_status_assertions.sv ----
// checker for the management pins of the basic status block
module pbs_basic_status_checker
    import pbs_pkg::*;
(
    input wire logic      clk,
    input wire logic      rst_n,
    input wire logic      mdc,
    input wire logic      mdio_in,
    input wire logic      mdio_out,
    input wire logic      mdio_oe_n,
    input pbs_status_in_s status_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // helper counters
    // ****************************************************************
    logic       mdc_reg;
    logic [2:0] gap_reg;
    logic [5:0] rise_reg;
    logic [5:0] lead_reg;
    logic       rise;
    assign rise = mdc && !mdc_reg;
    // mdc edge finder, cycles since last rise, rises since reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mdc_reg <= 1'h0;
            gap_reg <= 3'h7;
            lead_reg <= 6'h00;
        end else begin
            mdc_reg <= mdc;
            gap_reg <= rise ? 3'h0 : gap_reg + {2'h0, gap_reg != 3'h7};
            lead_reg <= lead_reg + {5'h00, rise && lead_reg != 6'h3F};
        end
    end
    // rises counted while the device drives the line
    always_ff @(posedge clk) begin
        if (!rst_n || mdio_oe_n) begin
            rise_reg <= 6'h00;
        end else begin
            rise_reg <= rise_reg + {5'h00, rise};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_reset_quiet: assert property ($rose(rst_n) |-> mdio_oe_n && mdio_out)
        else $error("line driven right after reset");
    a_idle_high: assert property (mdio_oe_n |-> mdio_out)
        else $error("data low while released");
    a_ta_zero: assert property (!mdio_oe_n && rise_reg == 6'h00 |-> !mdio_out)
        else $error("turnaround bit not zero");
    a_frame_len: assert property ($rose(mdio_oe_n) |-> rise_reg == 6'h11)
        else $error("read drive not 17 mdc periods");
    a_drive_bound: assert property (!mdio_oe_n |-> rise_reg <= 6'h11)
        else $error("drive runs past the data field");
    a_start_rise: assert property ($fell(mdio_oe_n) |-> gap_reg <= 3'h5)
        else $error("drive starts away from an mdc rise");
    a_bit_stands: assert property (!mdio_oe_n && !$past(mdio_oe_n) && $changed(mdio_out)
        |-> gap_reg <= 3'h5)
        else $error("data bit changed mid period");
    a_preamble_first: assert property ($fell(mdio_oe_n) |-> lead_reg >= 6'h2F)
        else $error("answer before a full preamble");
    c_read_start: cover property ($fell(mdio_oe_n));
    c_read_end: cover property ($rose(mdio_oe_n));
    c_fault: cover property (status_in.remote_fault && status_in.jabber && status_in.speed_10);
endmodule : pbs_basic_status_checker

bind pbs_basic_status pbs_basic_status_checker pbs_basic_status_checker_inst (
    .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .status_in(status_in));

// ---- testbench/pbs_smc_model.sv ----
// station management controller model driving mdc and its side of mdio
module pbs_smc_model
    import pbs_pkg::*;
(
    output logic      mdc,
    output logic      drv_en,
    output logic      drv_val,
    input  wire logic mdio_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 160; // half of the 320 ns mdc period
    // mdc rests low and the line is released between frames
    initial begin
        mdc = 1'h0;
        drv_en = 1'h0;
        drv_val = 1'h1;
    end
    // one mdc period: data set while low, line sampled at the rise
    task automatic one_bit(input logic en, input logic val, output logic seen);
        drv_en = en;
        drv_val = val;
        #HALF mdc = 1'h1;
        seen = mdio_wire;
        #HALF mdc = 1'h0;
    endtask : one_bit
    // whole frame; a read releases the line from the turnaround on
    task automatic frame(input logic pre, input logic [13:0] hdr, input logic [1:0] ta,
                         input logic [15:0] wd, output logic [15:0] rd, output logic hit);
        logic seen;
        logic is_rd;
        is_rd = (hdr[11:10] == PBS_OP_READ);
        if (pre) begin
            for (int i = 0; i < 32; i++) one_bit(1'h1, PBS_IDLE_LEVEL, seen);
        end
        for (int i = 13; i >= 0; i--) one_bit(1'h1, hdr[i], seen);
        for (int i = 1; i >= 0; i--) one_bit(!is_rd, ta[i], seen);
        hit = !seen; // device pulls the second turnaround bit low
        for (int i = 15; i >= 0; i--) begin
            one_bit(!is_rd, wd[i], seen);
            rd[i] = seen;
        end
        drv_en = 1'h0;
        #(2 * HALF);
    endtask : frame
endmodule : pbs_smc_model

// ---- testbench/tb_pbs_basic_status.sv ----
// self-checking testbench for the basic status management block
module tb_pbs_basic_status
    import pbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0]  PHY = 5'h0B;
    localparam logic [31:0] IDC = 32'hA5C3_0F19; // arbitrary identifier value
    localparam logic [4:0]  BS  = PBS_REG_BASIC_STATUS;
    logic           clk;
    logic           rst_n;
    pbs_status_in_s status_in;
    logic           mdc;
    logic           mdio_out;
    logic           mdio_oe_n;
    logic           drv_en;
    logic           drv_val;
    logic           mdio_wire;
    logic [15:0]    v;
    logic           hit;
    int             err_count = 0;
    int             total_checks = 0;
    // wire level: device, then controller, else the pull-up
    assign mdio_wire = !mdio_oe_n ? mdio_out : (drv_en ? drv_val : 1'h1);
    pbs_basic_status #(.PHY_ADDR(PHY), .ID_CODE(IDC)) pbs_basic_status_inst (
        .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_wire),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .status_in(status_in));
    pbs_smc_model pbs_smc_model_inst (
        .mdc(mdc), .drv_en(drv_en), .drv_val(drv_val), .mdio_wire(mdio_wire));
    always #20 clk = ~clk;
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic rd(input logic pre, input logic [4:0] phy, input logic [4:0] ra);
        @(negedge clk);
        pbs_smc_model_inst.frame(pre, {PBS_ST_FIRST, PBS_ST_SECOND, PBS_OP_READ, phy, ra},
                                 2'h3, 16'h0000, v, hit);
    endtask : rd
    task automatic wr(input logic [1:0] op, input logic [1:0] ta);
        @(negedge clk);
        pbs_smc_model_inst.frame(1'h0, {PBS_ST_FIRST, PBS_ST_SECOND, op, PHY, BS},
                                 ta, 16'h0000, v, hit);
    endtask : wr
    // expected status from {an_done, remote_fault, link_up, jabber}
    function automatic logic [15:0] bs(input logic [3:0] f);
        return 16'h7949 | {10'h000, f[3], f[2], 1'h0, f[1], f[0], 1'h0};
    endfunction : bs
    // status levels {an, fault, link, jabber, speed_10}
    task automatic put(input logic [4:0] s);
        @(negedge clk);
        status_in = pbs_status_in_s'(s);
    endtask : put
    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'h0;
        repeat (12) @(negedge clk);
        rst_n = 1'h1;
        repeat (4) @(negedge clk);
    endtask : do_reset
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_fixed();
        rd(1'h1, PHY, BS);
        check("answer", 16'h0001, {15'h0000, hit});
        check("status", bs(4'h0), v);
        rd(1'h0, PHY, BS);
        check("no preamble", bs(4'h0), v);
        $display("t_fixed done");
    endtask : t_fixed
    task automatic t_ident();
        rd(1'h0, PHY, PBS_REG_ID_HIGH);
        check("id high", IDC[31:16], v);
        rd(1'h0, PHY, PBS_REG_ID_LOW);
        check("id low", IDC[15:0], v);
        rd(1'h0, PHY, 5'h05);
        check("unmapped", 16'h0000, v);
        rd(1'h0, PHY ^ 5'h01, BS);
        check("other phy", 16'hFFFF, v);
        $display("t_ident done");
    endtask : t_ident
    task automatic t_latch();
        put(5'h0B);
        put(5'h01);
        rd(1'h0, PHY, BS);
        check("latched", bs(4'h5), v);
        rd(1'h0, PHY, BS);
        check("cleared", bs(4'h0), v);
        put(5'h02);
        put(5'h00);
        rd(1'h0, PHY, BS);
        check("jabber fast", bs(4'h0), v);
        put(5'h08);
        put(5'h00);
        do_reset();
        rd(1'h1, PHY, BS);
        check("fault reset", bs(4'h0), v);
        $display("t_latch done");
    endtask : t_latch
    task automatic t_link();
        put(5'h14);
        rd(1'h0, PHY, BS);
        check("link held low", bs(4'h8), v);
        rd(1'h0, PHY, BS);
        check("link up", bs(4'hA), v);
        put(5'h10);
        put(5'h14);
        rd(1'h0, PHY, BS);
        check("link drop", bs(4'h8), v);
        rd(1'h0, PHY, BS);
        check("link back", bs(4'hA), v);
        put(5'h04);
        rd(1'h0, PHY, BS);
        check("an cleared", bs(4'h2), v);
        $display("t_link done");
    endtask : t_link
    task automatic t_bad();
        wr(PBS_OP_WRITE, PBS_TA_WRITE);
        rd(1'h0, PHY, BS);
        check("after write", bs(4'h2), v);
        for (int k = 0; k < 3; k++) begin
            wr(k == 0 ? 2'h0 : k == 1 ? 2'h3 : PBS_OP_WRITE, k < 2 ? PBS_TA_WRITE : 2'h3);
            rd(1'h0, PHY, BS);
            check("silent", 16'h0000, {15'h0000, hit});
            rd(1'h1, PHY, BS);
            check("resync", bs(4'h2), v);
        end
        $display("t_bad done");
    endtask : t_bad
    // watchdog
    initial begin
        #2_000_000;
        err_count++;
        print_verdict();
    end
    // main sequence
    initial begin
        clk = 1'h0;
        rst_n = 1'h0;
        status_in = pbs_status_in_s'(5'h01);
        do_reset();
        t_fixed();
        t_ident();
        t_latch();
        t_link();
        t_bad();
        print_verdict();
    end
endmodule : tb_pbs_basic_status
